// ---- rtl/ist_pkg.sv ----
// package of constants and types for the i2c slave transmitter
`default_nettype none
package ist_pkg;
  // register word offsets (byte addresses)
  localparam logic [3:0] OFS_BUFFER = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_IRQ_STAT = 4'hc;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h0;
  localparam logic [3:0] OFS_ADDR = 4'h0;
  // control fields
  localparam int CTL_RELEASE_BIT = 4;
  localparam int CTL_OVERFLOW_BIT = 6;
  localparam int CTL_ENABLE_BIT = 5;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // status fields
  localparam int STA_FULL_BIT = 0;
  localparam int STA_RW_BIT = 2;
  localparam int STA_DATA_BIT = 5;
  localparam logic [7:0] STA_RESET = 8'h00;
  // interrupt events
  localparam int IRQ_BYTE_BIT = 0;
  localparam int IRQ_NACK_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // slave address register (7 bits)
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h50;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  // bus-slave answer time in clock cycles
  localparam int BUS_WAIT_CYCLES = 1;
  // link-side states, gray along idle-addr-ack-hold-shift-ackin
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b011,
    ST_HOLD = 3'b010,
    ST_SHIFT = 3'b110,
    ST_ACKIN = 3'b111,
    ST_SKIP = 3'b101
  } ist_state_t;
endpackage
`default_nettype wire

// ---- rtl/ist_pin_if.sv ----
// interface carrying synchronised pin levels and edges between modules
`default_nettype none
interface ist_pin_if;
  logic scl_lvl;
  logic sda_lvl;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sync (output scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
  modport core (input scl_lvl, sda_lvl, scl_rise, scl_fall, start_det, stop_det);
endinterface
`default_nettype wire

// ---- rtl/ist_pin_sync.sv ----
// three-stage pin synchroniser and bus-condition detector
`default_nettype none
module ist_pin_sync (
  input wire logic sys_clk_i,   // system clock
  input wire logic rst_n_i,     // synchronous reset, low active
  input wire logic scl_i,       // bus clock pin level
  input wire logic sda_i,       // data pin level
  ist_pin_if.sync pins          // filtered levels and edges
);
  logic [2:0] scl_sh;
  logic [2:0] sda_sh;
  logic scl_q;
  logic sda_q;
  logic [2:0] next_scl_sh;
  logic [2:0] next_sda_sh;
  logic next_scl_q;
  logic next_sda_q;

  // a change counts only once stages two and three agree
  always_comb begin
    next_scl_sh = {scl_sh[1:0], scl_i};
    next_sda_sh = {sda_sh[1:0], sda_i};
    next_scl_q = (scl_sh[2] == scl_sh[1]) ? scl_sh[2] : scl_q;
    next_sda_q = (sda_sh[2] == sda_sh[1]) ? sda_sh[2] : sda_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      scl_sh <= 3'h7;
      sda_sh <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sh <= next_scl_sh;
      sda_sh <= next_sda_sh;
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
    end
  end

  // edges of the filtered levels; start and stop are sda moves with scl high
  assign pins.scl_lvl = scl_q;
  assign pins.sda_lvl = sda_q;
  assign pins.scl_rise = next_scl_q & ~scl_q;
  assign pins.scl_fall = ~next_scl_q & scl_q;
  assign pins.start_det = scl_q & next_scl_q & sda_q & ~next_sda_q;
  assign pins.stop_det = scl_q & next_scl_q & ~sda_q & next_sda_q;
endmodule
`default_nettype wire

// ---- rtl/ist_top.sv ----
// i2c slave transmitter with avalon-mm register slave
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`default_nettype none
module ist_top (
  input wire logic sys_clk_i,              // 20 mhz system clock
  input wire logic rst_n_i,                // synchronous reset, low active
  input wire logic [3:0] avs_address_i,    // byte address
  input wire logic avs_read_i,             // read request
  input wire logic avs_write_i,            // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o,      // read data
  output logic avs_waitrequest_o,          // stall
  output logic irq_o,                      // level interrupt
  input wire logic scl_i,                  // bus clock pin level
  output logic scl_o,                      // bus clock drive value (always 0)
  output logic scl_oe_o,                   // bus clock pulled low
  input wire logic sda_i,                  // data pin level
  output logic sda_o,                      // data drive value (always 0)
  output logic sda_oe_o                    // data pulled low
);
  // local names for the package's state codes, nothing is imported
  localparam ist_pkg::ist_state_t ST_IDLE = ist_pkg::ST_IDLE;
  localparam ist_pkg::ist_state_t ST_ADDR = ist_pkg::ST_ADDR;
  localparam ist_pkg::ist_state_t ST_ACK = ist_pkg::ST_ACK;
  localparam ist_pkg::ist_state_t ST_HOLD = ist_pkg::ST_HOLD;
  localparam ist_pkg::ist_state_t ST_SHIFT = ist_pkg::ST_SHIFT;
  localparam ist_pkg::ist_state_t ST_ACKIN = ist_pkg::ST_ACKIN;
  localparam ist_pkg::ist_state_t ST_SKIP = ist_pkg::ST_SKIP;
  ist_pin_if pins ();

  ist_pin_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .pins(pins)
  );

  // ****************************************
  // register state
  // ****************************************
  logic [7:0] serial_byte_buffer;
  logic [7:0] serial_port_control;
  logic [7:0] port_status_reg;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [6:0] slave_addr;
  logic [31:0] rdata;
  logic ack_phase;
  logic [7:0] shift_register;
  logic [3:0] bit_cnt;
  logic sda_drv;
  logic scl_drv;
  ist_pkg::ist_state_t state;

  logic [7:0] next_buffer;
  logic [7:0] next_control;
  logic [7:0] next_status;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  logic [6:0] next_slave_addr;
  logic [31:0] next_rdata;
  logic next_ack_phase;
  logic [7:0] next_shift;
  logic [3:0] next_bit_cnt;
  logic next_sda_drv;
  logic next_scl_drv;
  ist_pkg::ist_state_t next_state;

  logic wr_hit;
  logic rd_hit;
  logic ev_byte;
  logic ev_nack;
  logic load_addr;
  logic load_tx;
  logic hold_start;
  logic status_clr;

  // byte-lane 0 write strobe for a given offset
  function automatic logic lane0_wr(input logic [3:0] ofs);
    lane0_wr = wr_hit && avs_address_i == ofs && avs_byteenable_i[0];
  endfunction

  // ****************************************
  // avalon slave: one wait cycle, then the access is taken
  // ****************************************
  always_comb begin
    wr_hit = avs_write_i && ack_phase;
    rd_hit = avs_read_i && ack_phase;
    next_ack_phase = (avs_read_i || avs_write_i) && !ack_phase;
    next_rdata = 32'h0000_0000;
    unique case (avs_address_i)
      ist_pkg::OFS_BUFFER: next_rdata[7:0] = serial_byte_buffer;
      ist_pkg::OFS_CONTROL: next_rdata[7:0] = serial_port_control;
      ist_pkg::OFS_STATUS: next_rdata[7:0] = port_status_reg;
      ist_pkg::OFS_IRQ_STAT: next_rdata = {14'h0000, irq_mask, 9'h000, slave_addr};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // link-side state machine
  // ****************************************
  always_comb begin
    next_state = state;
    next_shift = shift_register;
    next_bit_cnt = bit_cnt;
    next_sda_drv = sda_drv;
    next_scl_drv = scl_drv;
    ev_byte = 1'b0;
    ev_nack = 1'b0;
    load_addr = 1'b0;
    hold_start = 1'b0;
    status_clr = 1'b0;
    if (pins.start_det && serial_port_control[ist_pkg::CTL_ENABLE_BIT]) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
    end else if (pins.stop_det) begin
      next_state = ST_IDLE;
      next_sda_drv = 1'b0;
      next_scl_drv = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: next_state = ST_IDLE;
        ST_ADDR: begin
          if (pins.scl_rise) begin
            next_shift = {shift_register[6:0], pins.sda_lvl};
            next_bit_cnt = bit_cnt + 4'h1;
          end
          if (pins.scl_fall && bit_cnt == ist_pkg::BIT_LAST) begin
            if (shift_register[7:1] == slave_addr && shift_register[0]) begin
              load_addr = 1'b1;
              next_sda_drv = 1'b1;    // acknowledge on the ninth bit
              next_state = ST_ACK;
            end else begin
              next_state = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (pins.scl_fall) begin
            ev_byte = 1'b1;
            next_sda_drv = 1'b0;
            next_scl_drv = 1'b1;      // stretch after the acknowledge
            hold_start = 1'b1;
            next_state = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // release only with release bit set; first bit on bus at release
          if (serial_port_control[ist_pkg::CTL_RELEASE_BIT]) begin
            next_scl_drv = 1'b0;
            next_sda_drv = ~shift_register[7];
            next_shift = {shift_register[6:0], 1'b0};
            next_bit_cnt = 4'h1;
            next_state = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (pins.scl_fall) begin
            if (bit_cnt == ist_pkg::BIT_LAST) begin
              next_sda_drv = 1'b0;    // free data for master acknowledge
              next_state = ST_ACKIN;
            end else begin
              next_sda_drv = ~shift_register[7]; // change on falling edge
              next_shift = {shift_register[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ST_ACKIN: begin
          if (pins.scl_rise) begin
            next_bit_cnt = ist_pkg::BIT_ACK;
            next_shift[0] = pins.sda_lvl; // latch acknowledge
          end
          if (pins.scl_fall && bit_cnt == ist_pkg::BIT_ACK) begin
            ev_byte = 1'b1;
            if (shift_register[0]) begin
              ev_nack = 1'b1;
              status_clr = 1'b1;
              next_state = ST_IDLE;
            end else begin
              next_scl_drv = 1'b1;    // wait for next byte
              hold_start = 1'b1;
              next_state = ST_HOLD;
            end
          end
        end
        ST_SKIP: next_state = ST_SKIP;
        default: next_state = ST_IDLE;
      endcase
    end
    load_tx = lane0_wr(ist_pkg::OFS_BUFFER);
    if (load_tx) begin
      next_shift = avs_writedata_i[7:0];
    end
  end

  // ****************************************
  // register next values
  // ****************************************
  always_comb begin
    next_buffer = serial_byte_buffer;
    next_control = serial_port_control;
    next_status = port_status_reg;
    next_slave_addr = slave_addr;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (load_tx) begin
      next_buffer = avs_writedata_i[7:0];
      next_status[ist_pkg::STA_FULL_BIT] = 1'b1;
    end
    if (lane0_wr(ist_pkg::OFS_CONTROL)) begin
      next_control = avs_writedata_i[7:0]; // overflow cleared by software
    end
    if (wr_hit && avs_address_i == ist_pkg::OFS_IRQ_STAT) begin
      if (avs_byteenable_i[0]) begin
        next_slave_addr = avs_writedata_i[6:0];
      end
      if (avs_byteenable_i[2]) begin
        next_irq_mask = avs_writedata_i[17:16];
      end
    end
    if (rd_hit && avs_address_i == ist_pkg::OFS_BUFFER) begin
      next_status[ist_pkg::STA_FULL_BIT] = 1'b0;
    end
    if (hold_start) begin
      next_control[ist_pkg::CTL_RELEASE_BIT] = 1'b0;
      next_status[ist_pkg::STA_FULL_BIT] = load_tx; // a same-cycle load keeps full set
    end
    if (load_addr) begin
      next_buffer = shift_register;
      next_status[ist_pkg::STA_RW_BIT] = 1'b1;
      next_status[ist_pkg::STA_DATA_BIT] = 1'b0;
    end
    if (ev_byte && !load_addr && state == ST_ACKIN) begin
      next_status[ist_pkg::STA_DATA_BIT] = 1'b1;   // last byte was data
    end
    if (status_clr) begin
      next_status = ist_pkg::STA_RESET;
    end
    // reading status clears; a same-cycle event still sets (set wins)
    if (rd_hit && avs_address_i == ist_pkg::OFS_IRQ_STAT) begin
      next_irq_stat = ist_pkg::IRQ_RESET;
    end
    if (ev_byte) begin
      next_irq_stat[ist_pkg::IRQ_BYTE_BIT] = 1'b1;
    end
    if (ev_nack) begin
      next_irq_stat[ist_pkg::IRQ_NACK_BIT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      shift_register <= 8'h00;
      bit_cnt <= 4'h0;
      sda_drv <= 1'b0;
      scl_drv <= 1'b0;
      serial_byte_buffer <= 8'h00;
      serial_port_control <= ist_pkg::CTL_RESET;
      port_status_reg <= ist_pkg::STA_RESET;
      irq_stat <= ist_pkg::IRQ_RESET;
      irq_mask <= 2'h0;
      slave_addr <= ist_pkg::SLAVE_ADDR_RESET;
      rdata <= 32'h0000_0000;
      ack_phase <= 1'b0;
    end else begin
      state <= next_state;
      shift_register <= next_shift;
      bit_cnt <= next_bit_cnt;
      sda_drv <= next_sda_drv;
      scl_drv <= next_scl_drv;
      serial_byte_buffer <= next_buffer;
      serial_port_control <= next_control;
      port_status_reg <= next_status;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      slave_addr <= next_slave_addr;
      rdata <= next_rdata;
      ack_phase <= next_ack_phase;
    end
  end

  // ****************************************
  // outputs, from flops except the constant drive values
  // ****************************************
  logic irq_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(next_irq_stat & next_irq_mask);
    end
  end
  assign irq_o = irq_q;
  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = ~ack_phase;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drv;
  assign sda_oe_o = sda_drv;

  // ****************************************
  // checks
  // ****************************************
  hold_clears_rel_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(scl_drv) |-> !serial_port_control[ist_pkg::CTL_RELEASE_BIT])
    else $error("release bit not cleared at hold");
  release_needs_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ($fell(scl_drv) && $past(state) == ST_HOLD)
      |-> $past(serial_port_control[ist_pkg::CTL_RELEASE_BIT]))
    else $error("clock released without release bit");
  addr_read_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    load_addr |=> port_status_reg[ist_pkg::STA_RW_BIT] && state == ST_ACK)
    else $error("read flag not set on address match");
  addr_to_buf_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    load_addr |=> serial_byte_buffer == $past(shift_register))
    else $error("address not copied to buffer");
  ack_drive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_ACK |-> sda_oe_o)
    else $error("no acknowledge during ninth bit");
  tx_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    load_tx |=> shift_register == $past(avs_writedata_i[7:0]))
    else $error("shift register not loaded");
  nack_ends_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ev_nack |=> state == ST_IDLE && port_status_reg == 8'h00 && !scl_oe_o)
    else $error("not-acknowledge did not end transfer");
  byte_irq_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ev_byte |=> irq_stat[ist_pkg::IRQ_BYTE_BIT])
    else $error("byte flag not set");
  buf_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (rd_hit && avs_address_i == 4'h0 && !load_tx) |=> !port_status_reg[0])
    else $error("full flag not cleared by read");
  ack_hold_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_ACKIN ##1 state == ST_HOLD);
  nack_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) ev_nack);
  release_c: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == ST_HOLD ##1 state == ST_SHIFT);
endmodule
`default_nettype wire

// ---- verification/ist_bus_master.sv ----
// i2c master receiver model on open-drain clock and data lines
`default_nettype none
module ist_bus_master (
  input wire logic scl_i,  // clock line level
  input wire logic sda_i,  // data line level
  output logic scl_low_o,  // pull clock line low
  output logic sda_low_o   // pull data line low
);
  timeunit 1ns;
  timeprecision 1ns;
  int stretch_errs = 0;
  int glitch_errs = 0;
  // ****************************************
  // line drivers
  // ****************************************
  // both lines start released, the pull-ups hold them high
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
  end
  // one 400 ns bit: 250 ns low, 150 ns high, data read 50 ns into the high phase
  task automatic pulse(input logic b, output logic s);
    int n;
    n = 0;
    #50 sda_low_o = ~b;
    #200 scl_low_o = 1'b0;
    // a slave may stretch the low phase, so wait for the line itself
    while (scl_i !== 1'b1 && n < 2000) begin
      #25 n++;
    end
    if (n >= 2000) stretch_errs++;
    #50 s = sda_i;
    // data must not move while the clock is high
    #100 if (sda_i !== s) glitch_errs++;
    scl_low_o = 1'b1;
  endtask
  // start: data falls while the clock is high
  task automatic start_cond();
    // step off the system clock edges so the pins never race the sampler
    #10;
    sda_low_o = 1'b1;
    #200 scl_low_o = 1'b1;
  endtask
  // stop: data rises while the clock is high
  task automatic stop_cond();
    #50 sda_low_o = 1'b1;
    #200 scl_low_o = 1'b0;
    #200 sda_low_o = 1'b0;
    #200;
  endtask
  // address byte msb first, returns the slave's ninth bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], s);
    end
    pulse(1'b1, ack);
  endtask
  // read one byte, then low on the ninth bit for more, high to end
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      d[i] = s;
    end
    pulse(~more, s);
  endtask
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking testbench for the i2c slave transmitter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl, m_sda;
  wire logic scl_line;
  wire logic sda_line;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  logic ack;
  logic [7:0] b0, b1;
  // open-drain lines with pull-ups
  assign scl_line = ~(scl_oe_o | m_scl);
  assign sda_line = ~(sda_oe_o | m_sda);
  // ****************************************
  // clock, timeout and instances
  // ****************************************
  // 50 ns system clock
  always #25 sys_clk_i = ~sys_clk_i;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  ist_top u_ist_top (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  ist_bus_master u_ist_bus_master (.scl_i(scl_line), .sda_i(sda_line), .scl_low_o(m_scl),
    .sda_low_o(m_sda));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", nm, exp, got);
      fail_count++;
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
    input logic [3:0] be, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= ~w;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    chk("bus_answer", 32'h0, {31'h0, avs_waitrequest_o});
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] d;
    bus(1'b1, a, wd, be, d);
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, 4'hf, d);
    chk(nm, exp, d);
  endtask
  task automatic wait_irq(input string nm);
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 4000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(nm, 32'h1, {31'h0, irq_o});
  endtask
  // load a byte, check full flag handling, then release the held clock
  task automatic load_byte(input logic [7:0] v, input logic [7:0] sta);
    wr(ist_pkg::OFS_BUFFER, {24'h0, v}, 4'h1);
    rc("sta_full", ist_pkg::OFS_STATUS, {24'h0, sta | 8'h01});
    rc("buf_back", ist_pkg::OFS_BUFFER, {24'h0, v});
    rc("full_clr", ist_pkg::OFS_STATUS, {24'h0, sta});
    chk("still_held", 32'h1, {31'h0, scl_oe_o});
    wr(ist_pkg::OFS_CONTROL, 32'h30, 4'h1);
  endtask
  // clear the sticky events by reading them
  task automatic clr_irq();
    rc("irq_read", ist_pkg::OFS_IRQ_STAT, 32'h0003_0050);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_clr", 32'h0, {31'h0, irq_o});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    chk("oe_rst", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
    chk("drv_lvl", 32'h0, {30'h0, scl_o, sda_o});
    rc("ctl_rst", ist_pkg::OFS_CONTROL, 32'h0);
    rc("sta_rst", ist_pkg::OFS_STATUS, 32'h0);
    rc("unmapped", 4'h2, 32'h0);
    wr(ist_pkg::OFS_IRQ_STAT, 32'h0003_0050, 4'h5);
    wr(ist_pkg::OFS_CONTROL, 32'h20, 4'h1);
    // a read aimed at another address gets no acknowledge and no event
    u_ist_bus_master.start_cond();
    u_ist_bus_master.send_byte(8'ha3, ack);
    u_ist_bus_master.stop_cond();
    chk("foreign_ack", 32'h1, {31'h0, ack});
    chk("foreign_irq", 32'h0, {31'h0, irq_o});
    // matched read of two bytes, software serving the stretched clock
    fork
      begin
        u_ist_bus_master.start_cond();
        u_ist_bus_master.send_byte(8'ha1, ack);
        chk("addr_ack", 32'h0, {31'h0, ack});
        u_ist_bus_master.recv_byte(1'b1, b0);
        u_ist_bus_master.recv_byte(1'b0, b1);
        u_ist_bus_master.stop_cond();
      end
      begin
        wait_irq("addr_irq");
        chk("addr_hold", 32'h1, {31'h0, scl_oe_o});
        rc("addr_sta", ist_pkg::OFS_STATUS, 32'h04);
        rc("addr_buf", ist_pkg::OFS_BUFFER, 32'ha1);
        rc("ctl_auto", ist_pkg::OFS_CONTROL, 32'h20);
        chk("irq_sticky", 32'h1, {31'h0, irq_o});
        clr_irq();
        load_byte(8'ha5, 8'h04);
        wait_irq("byte_irq");
        chk("irq_scl_low", 32'h0, {31'h0, scl_line});
        rc("data_sta", ist_pkg::OFS_STATUS, 32'h24);
        rc("ctl_auto2", ist_pkg::OFS_CONTROL, 32'h20);
        clr_irq();
        load_byte(8'h3c, 8'h24);
      end
    join
    chk("byte0", {24'h0, 8'ha5}, {24'h0, b0});
    chk("byte1", {24'h0, 8'h3c}, {24'h0, b1});
    wait_irq("nack_irq");
    rc("nack_sta", ist_pkg::OFS_STATUS, 32'h0);
    chk("nack_oe", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
    // masking hides pending events, unmasking shows them again
    wr(ist_pkg::OFS_IRQ_STAT, 32'h0, 4'h4);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_masked", 32'h0, {31'h0, irq_o});
    // the not-acknowledge event alone must still raise the line
    wr(ist_pkg::OFS_IRQ_STAT, 32'h0002_0000, 4'h4);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_nack_only", 32'h1, {31'h0, irq_o});
    wr(ist_pkg::OFS_IRQ_STAT, 32'h0003_0000, 4'h4);
    repeat (2) @(posedge sys_clk_i);
    chk("irq_unmask", 32'h1, {31'h0, irq_o});
    clr_irq();
    chk("stretch", 32'h0, u_ist_bus_master.stretch_errs);
    chk("sda_stable", 32'h0, u_ist_bus_master.glitch_errs);
    close_out();
  end
endmodule
`default_nettype wire
